// ==== rtl/pfp_flash_protect.sv ====
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ns
// Function
// [RQ1] configuration bits reachable only through the serial programmer port
// [RQ2] write protection, once on, stays on until a full device erase
// [RQ3] active write protection blocks firmware writes to program flash
// [RQ4] program memory reads work regardless of the write-protect bit
// [RQ5] code protect 00: internal read only, everything else refused
// [RQ6] code protect 11, protect on: all allowed except internal write
// [RQ7] code protect 11, protect off: every access allowed
// [RQ8] partial protect: protected area internal read only
// [RQ9] partial, protect off, unprotected area: all but programmer write
// [RQ10] partial, protect on, unprotected area: internal and programmer reads only
// [RQ11] refused writes change nothing; refused programmer reads return a fixed word
module pfp_flash_protect (
    input  wire logic        core_clk,     // 125 MHz system clock
    input  wire logic        srst,         // synchronous reset, active high
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write enable
    input  wire logic [11:0] wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    output logic      [31:0] wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    input  wire logic        prog_mode,    // serial programming mode active
    input  wire logic        prog_req,     // programmer request pulse
    input  wire logic        prog_we,      // programmer request is a write
    input  wire logic        prog_cfg,     // request targets the config word
    input  wire logic        prog_erase,   // request is a full device erase
    input  wire logic [10:0] prog_addr,    // programmer word address
    input  wire logic [13:0] prog_wdata,   // programmer write word
    output logic      [13:0] prog_rdata,   // programmer read word
    output logic             prog_ack,     // programmer request done
    output logic             prog_denied,  // programmer access refused
    output logic             nvm_busy      // erase walk in progress
);
    logic [13:0] flash_mem [0:pfp_pkg::PGM_WORDS-1];
    logic [7:0]  ee_mem    [0:pfp_pkg::EE_BYTES-1];
    logic [7:0]  data_lo_r;
    logic [5:0]  data_hi_r;
    logic [7:0]  addr_lo_r;
    logic [2:0]  addr_hi_r;
    logic        eepgd_r;
    logic        wrerr_r;
    logic        wren_r;
    logic        wr_r;
    logic        rd_r;
    logic        wb_ack_r;
    logic [31:0] wb_dat_r;
    logic [13:0] prog_rdata_r;
    logic        prog_ack_r;
    logic        prog_denied_r;
    logic [10:0] erase_cnt_r;
    logic        cfg_wp_r;
    logic [1:0]  cfg_cp_r;
    pfp_pkg::pfp_unlock_t unl_r;
    pfp_pkg::pfp_unlock_t unl_nxt;
    pfp_pkg::pfp_state_t  st_r;
    function automatic logic in_prot(input logic [1:0] cp, input logic [10:0] a);
        in_prot = (cp == pfp_pkg::CP_HALF && a >= pfp_pkg::PROT_BASE_HALF) ||
                  (cp == pfp_pkg::CP_QTR && a >= pfp_pkg::PROT_BASE_QTR);
    endfunction : in_prot
    // result bits: internal read, internal write, programmer read, programmer write
    function automatic logic [3:0] access_ok(input logic [1:0] cp, input logic wp,
                                             input logic prot);
        if (cp == pfp_pkg::CP_ALL) begin
            access_ok = 4'h8;                   // [RQ5]
        end else if (cp == pfp_pkg::CP_OFF) begin
            access_ok = {1'b1, wp, 2'h3};       // [RQ6] [RQ7]
        end else if (prot) begin
            access_ok = 4'h8;                   // [RQ8]
        end else begin
            access_ok = {1'b1, wp, 2'h2};       // [RQ9] [RQ10]
        end
    endfunction : access_ok
    // wishbone decode
    logic [9:0]  wb_idx;
    logic        bus_req;
    logic        bus_wr;
    logic        hit_dlo;
    logic        hit_dhi;
    logic        hit_alo;
    logic        hit_ahi;
    logic        hit_ctl;
    logic        hit_unl;
    logic [7:0]  ctl_rd;
    logic [31:0] rd_mux;
    assign wb_idx  = wb_adr_i[11:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    assign hit_dlo = wb_idx == pfp_pkg::IDX_DATA_LO;
    assign hit_dhi = wb_idx == pfp_pkg::IDX_DATA_HI;
    assign hit_alo = wb_idx == pfp_pkg::IDX_ADDR_LO;
    assign hit_ahi = wb_idx == pfp_pkg::IDX_ADDR_HI;
    assign hit_ctl = wb_idx == pfp_pkg::IDX_ACCESS_CTL;
    assign hit_unl = wb_idx == pfp_pkg::IDX_UNLOCK;
    assign ctl_rd  = {eepgd_r, 3'h0, wrerr_r, wren_r, wr_r, rd_r};
    // unmapped addresses and the unlock register read as zero
    assign rd_mux  = hit_dlo ? {24'h0, data_lo_r} :
                     hit_dhi ? {26'h0, data_hi_r} :
                     hit_alo ? {24'h0, addr_lo_r} :
                     hit_ahi ? {29'h0, addr_hi_r} :
                     hit_ctl ? {24'h0, ctl_rd} : 32'h0;
    // firmware side
    logic        wr_ctl;
    logic        wr_unl;
    logic        sw_rd_set;
    logic        sw_wr_set;
    logic        sw_err_clr;
    logic [10:0] fw_addr;
    logic [13:0] fw_word;
    logic [3:0]  fw_ok;
    logic        fw_prot;
    logic        hw_busy;
    logic        fw_pgm_wr_ok;
    logic        fw_ee_wr_ok;
    logic        fw_refuse;
    assign wr_ctl     = bus_wr & hit_ctl;
    assign wr_unl     = bus_wr & hit_unl;
    assign sw_rd_set  = wr_ctl & wb_dat_i[pfp_pkg::ACTL_RD];
    // the write strobe only takes after the two-key unlock with writes enabled
    assign sw_wr_set  = wr_ctl & wb_dat_i[pfp_pkg::ACTL_WR] & wren_r & ~wr_r &
                        (unl_r == pfp_pkg::PFP_ARMED);
    assign sw_err_clr = wr_ctl & ~wb_dat_i[pfp_pkg::ACTL_ERR];
    assign fw_addr    = {addr_hi_r, addr_lo_r};
    assign fw_word    = flash_mem[fw_addr];
    assign fw_prot    = in_prot(cfg_cp_r, fw_addr);
    assign fw_ok      = access_ok(cfg_cp_r, cfg_wp_r, fw_prot);
    // firmware writes are held off while the programmer owns the arrays
    assign hw_busy    = prog_mode | (st_r == pfp_pkg::PFP_ERASE);
    assign fw_pgm_wr_ok = wr_r & eepgd_r & fw_ok[2] & ~hw_busy;  // [RQ3]
    assign fw_ee_wr_ok  = wr_r & ~eepgd_r & ~hw_busy;
    assign fw_refuse    = wr_r & ~fw_pgm_wr_ok & ~fw_ee_wr_ok;     // [RQ11]
    // programmer side
    logic        ext_go;
    logic        ext_erase;
    logic        ext_cfg_rd;
    logic        ext_cfg_wr;
    logic        ext_flash_rd;
    logic        ext_flash_wr;
    logic [3:0]  ext_ok;
    logic        ext_prot;
    logic        erase_done;
    logic [13:0] cfg_word;
    assign ext_go       = prog_mode & prog_req & (st_r == pfp_pkg::PFP_IDLE);
    assign ext_erase    = ext_go & prog_erase;
    assign ext_cfg_rd   = ext_go & ~prog_erase & prog_cfg & ~prog_we;
    assign ext_cfg_wr   = ext_go & ~prog_erase & prog_cfg & prog_we;   // [RQ1]
    assign ext_flash_rd = ext_go & ~prog_erase & ~prog_cfg & ~prog_we;
    assign ext_flash_wr = ext_go & ~prog_erase & ~prog_cfg & prog_we;
    assign ext_prot     = in_prot(cfg_cp_r, prog_addr);
    assign ext_ok       = access_ok(cfg_cp_r, cfg_wp_r, ext_prot);
    assign erase_done   = (st_r == pfp_pkg::PFP_ERASE) && (erase_cnt_r == pfp_pkg::PGM_LAST);
    // unused config bits read as erased ones
    assign cfg_word     = {pfp_pkg::PGM_BLANK[13:10], cfg_wp_r, pfp_pkg::PGM_BLANK[8:6],
                           cfg_cp_r, pfp_pkg::PGM_BLANK[3:0]};
    // array write ports
    logic        pgm_we;
    logic [10:0] pgm_wa;
    logic [13:0] pgm_wd;
    logic        ee_we;
    logic [5:0]  ee_wa;
    logic [7:0]  ee_wd;
    logic        erasing;
    assign erasing = st_r == pfp_pkg::PFP_ERASE;
    assign pgm_we  = erasing | (ext_flash_wr & ext_ok[0]) | fw_pgm_wr_ok;  // [RQ11]
    assign pgm_wa  = erasing ? erase_cnt_r : ext_flash_wr ? prog_addr : fw_addr;
    assign pgm_wd  = erasing ? pfp_pkg::PGM_BLANK :
                     ext_flash_wr ? prog_wdata : {data_hi_r, data_lo_r};
    assign ee_we   = erasing | fw_ee_wr_ok;
    assign ee_wa   = erasing ? erase_cnt_r[5:0] : addr_lo_r[5:0];
    assign ee_wd   = erasing ? pfp_pkg::EE_BLANK : data_lo_r;
    always_comb begin
        unl_nxt = unl_r;
        if (wr_unl) begin
            if (wb_dat_i[7:0] == pfp_pkg::UNLOCK_KEY1) begin
                unl_nxt = pfp_pkg::PFP_HALF_KEY;
            end else if (wb_dat_i[7:0] == pfp_pkg::UNLOCK_KEY2 &&
                         unl_r == pfp_pkg::PFP_HALF_KEY) begin
                unl_nxt = pfp_pkg::PFP_ARMED;
            end else begin
                unl_nxt = pfp_pkg::PFP_LOCKED;
            end
        end else if (bus_wr) begin
            // any other register write between keys breaks the sequence
            unl_nxt = pfp_pkg::PFP_LOCKED;
        end
    end

    always_ff @(posedge core_clk) begin
        if (pgm_we) begin
            flash_mem[pgm_wa] <= pgm_wd;
        end
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
    end

    // nonvolatile: survives srst, only a full erase returns it to the blank state
    always_ff @(posedge core_clk) begin
        if (erase_done) begin
            cfg_wp_r <= 1'b1;                                           // [RQ2]
            cfg_cp_r <= pfp_pkg::CP_OFF;
        end else if (ext_cfg_wr) begin
            // programming can only tighten protection
            cfg_wp_r <= cfg_wp_r & prog_wdata[pfp_pkg::CFG_WP];         // [RQ1] [RQ2]
            cfg_cp_r <= cfg_cp_r & prog_wdata[pfp_pkg::CFG_CP_HI:pfp_pkg::CFG_CP_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0;
            unl_r    <= pfp_pkg::PFP_LOCKED;
        end else begin
            wb_ack_r <= bus_req;
            wb_dat_r <= bus_req ? rd_mux : 32'h0;
            unl_r    <= sw_wr_set ? pfp_pkg::PFP_LOCKED : unl_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            eepgd_r <= 1'b0;
            wren_r  <= 1'b0;
            rd_r    <= 1'b0;
            wr_r    <= 1'b0;
            wrerr_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                eepgd_r <= wb_dat_i[pfp_pkg::ACTL_PGM];
                wren_r  <= wb_dat_i[pfp_pkg::ACTL_WEN];
            end
            // a hardware error set wins over the software clear of the same cycle
            rd_r    <= sw_rd_set;
            wr_r    <= sw_wr_set;
            wrerr_r <= fw_refuse | (wrerr_r & ~sw_err_clr);
        end
    end

    // a program read strobe loads the data pair, an eeprom read only data_lo_r, one cycle later, over any bus write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_lo_r <= 8'h0;
            data_hi_r <= 6'h0;
            addr_lo_r <= 8'h0;
            addr_hi_r <= 3'h0;
        end else if (rd_r && eepgd_r) begin
            data_lo_r <= fw_word[7:0];                                  // [RQ4]
            data_hi_r <= fw_word[13:8];
        end else if (rd_r) begin
            data_lo_r <= ee_mem[addr_lo_r[5:0]];
        end else begin
            if (bus_wr && hit_dlo) data_lo_r <= wb_dat_i[7:0];
            if (bus_wr && hit_dhi) data_hi_r <= wb_dat_i[5:0];
            if (bus_wr && hit_alo) addr_lo_r <= wb_dat_i[7:0];
            if (bus_wr && hit_ahi) addr_hi_r <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r          <= pfp_pkg::PFP_IDLE;
            erase_cnt_r   <= 11'h0;
            prog_ack_r    <= 1'b0;
            prog_denied_r <= 1'b0;
            prog_rdata_r  <= 14'h0;
        end else begin
            case (st_r)
                pfp_pkg::PFP_IDLE: begin
                    if (ext_erase) begin
                        st_r <= pfp_pkg::PFP_ERASE;
                    end
                    erase_cnt_r <= 11'h0;
                end
                default: begin
                    if (erase_done) begin
                        st_r <= pfp_pkg::PFP_IDLE;
                    end
                    erase_cnt_r <= erase_cnt_r + 11'h1;
                end
            endcase
            prog_ack_r    <= (ext_go & ~prog_erase) | erase_done;
            prog_denied_r <= (ext_flash_rd & ~ext_ok[1]) | (ext_flash_wr & ~ext_ok[0]);
            if (ext_cfg_rd) begin
                prog_rdata_r <= cfg_word;                               // [RQ1]
            end else if (ext_flash_rd) begin
                prog_rdata_r <= ext_ok[1] ? flash_mem[prog_addr] : pfp_pkg::DENIED_WORD;
            end else if (ext_go | erase_done) begin
                prog_rdata_r <= 14'h0;
            end
        end
    end

    assign wb_ack_o    = wb_ack_r;
    assign wb_dat_o    = wb_dat_r;
    assign prog_ack    = prog_ack_r;
    assign prog_denied = prog_denied_r;
    assign prog_rdata  = prog_rdata_r;
    assign nvm_busy    = erasing;
    default clocking pfp_cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_ext_rd_denied;
        ext_flash_rd && !ext_ok[1];
    endsequence
    sequence s_denied_answer;
        prog_ack && prog_denied && prog_rdata == pfp_pkg::DENIED_WORD;
    endsequence
    chk_cfg_prog_only: assert property (!ext_cfg_wr && !erase_done |=> // [RQ1]
        $stable(cfg_wp_r) && $stable(cfg_cp_r))
        else $error("config word changed outside programming mode");
    chk_wp_sticky: assert property (!cfg_wp_r && !erasing |=> !cfg_wp_r) // [RQ2]
        else $error("write protection released without full erase");
    chk_wp_blocks: assert property (wr_r && eepgd_r && !cfg_wp_r |-> !pgm_we) // [RQ3]
        else $error("program write passed while write protected");
    chk_read_any: assert property (rd_r && eepgd_r |=> // [RQ4]
        data_lo_r == $past(fw_word[7:0]) && data_hi_r == $past(fw_word[13:8]))
        else $error("program read did not load the data pair");
    chk_cp_all: assert property (cfg_cp_r == pfp_pkg::CP_ALL |-> // [RQ5]
        fw_ok == 4'h8 && ext_ok == 4'h8)
        else $error("full code protect allows a refused access");
    chk_cp_off_wp: assert property (cfg_cp_r == pfp_pkg::CP_OFF && !cfg_wp_r |-> // [RQ6]
        fw_ok == 4'hB && ext_ok == 4'hB)
        else $error("unprotected code with write protect wrong");
    chk_cp_off_open: assert property (cfg_cp_r == pfp_pkg::CP_OFF && cfg_wp_r |-> // [RQ7]
        fw_ok == 4'hF && ext_ok == 4'hF)
        else $error("fully open configuration refuses an access");
    chk_part_prot: assert property (ext_prot |-> ext_ok == 4'h8) // [RQ8]
        else $error("protected area allows more than internal read");
    chk_part_open: assert property ((cfg_cp_r == pfp_pkg::CP_HALF || // [RQ9]
        cfg_cp_r == pfp_pkg::CP_QTR) && !fw_prot && cfg_wp_r |-> fw_ok == 4'hE)
        else $error("partial protect unprotected area wrong, protect off");
    chk_part_wp: assert property ((cfg_cp_r == pfp_pkg::CP_HALF || // [RQ10]
        cfg_cp_r == pfp_pkg::CP_QTR) && !ext_prot && !cfg_wp_r |-> ext_ok == 4'hA)
        else $error("partial protect unprotected area wrong, protect on");
    chk_denied_read: assert property (s_ext_rd_denied |=> s_denied_answer) // [RQ11]
        else $error("refused programmer read leaked data");
    chk_refused_wr: assert property (fw_refuse |=> wrerr_r && !wr_r) // [RQ11]
        else $error("refused firmware write not flagged");

endmodule : pfp_flash_protect

// ==== rtl/pfp_pkg.sv ====
package pfp_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [9:0]  IDX_DATA_LO    = 10'h10C;
    localparam logic [9:0]  IDX_ADDR_LO    = 10'h10D;
    localparam logic [9:0]  IDX_DATA_HI    = 10'h10E;
    localparam logic [9:0]  IDX_ADDR_HI    = 10'h10F;
    localparam logic [9:0]  IDX_ACCESS_CTL = 10'h18C;
    localparam logic [9:0]  IDX_UNLOCK     = 10'h18D;

    // access control field positions
    localparam int          ACTL_PGM = 7;
    localparam int          ACTL_ERR = 3;
    localparam int          ACTL_WEN = 2;
    localparam int          ACTL_WR  = 1;
    localparam int          ACTL_RD  = 0;

    localparam logic [7:0]  UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0]  UNLOCK_KEY2 = 8'hAA;

    localparam int          PGM_AW    = 11;
    localparam int          PGM_DW    = 14;
    localparam int          PGM_WORDS = 2048;
    localparam int          EE_AW     = 6;
    localparam int          EE_BYTES  = 64;
    localparam logic [10:0] PGM_LAST  = 11'h7FF;

    localparam logic [13:0] PGM_BLANK   = 14'h3FFF;
    localparam logic [7:0]  EE_BLANK    = 8'hFF;
    localparam logic [13:0] DENIED_WORD = 14'h0000;

    // configuration word layout and code-protect field encodings
    localparam int          CFG_WP    = 9;
    localparam int          CFG_CP_LO = 4;
    localparam int          CFG_CP_HI = 5;
    localparam logic [1:0]  CP_ALL    = 2'h0;
    localparam logic [1:0]  CP_HALF   = 2'h1;
    localparam logic [1:0]  CP_QTR    = 2'h2;
    localparam logic [1:0]  CP_OFF    = 2'h3;
    localparam logic [10:0] PROT_BASE_HALF = 11'h400;
    localparam logic [10:0] PROT_BASE_QTR  = 11'h600;

    typedef enum logic [1:0] {PFP_LOCKED, PFP_HALF_KEY, PFP_ARMED} pfp_unlock_t;
    typedef enum logic {PFP_IDLE, PFP_ERASE} pfp_state_t;
endpackage : pfp_pkg

// ==== verif/pfp_prog_model.sv ====
`timescale 1ns/1ns
// serial programmer stand-in; the bench drives it through its tasks
module pfp_prog_model (
    input  wire logic        core_clk,    // system clock
    output logic             prog_mode,   // programmer owns the part
    output logic             prog_req,    // request pulse
    output logic             prog_we,     // write request
    output logic             prog_cfg,    // config word target
    output logic             prog_erase,  // full device erase
    output logic      [10:0] prog_addr,   // word address
    output logic      [13:0] prog_wdata,  // write word
    input  wire logic [13:0] prog_rdata,  // read word
    input  wire logic        prog_ack,    // request done
    input  wire logic        prog_denied  // request refused
);
    initial begin
        prog_mode = 1'b0;
        prog_req = 1'b0;
        prog_we = 1'b0;
        prog_cfg = 1'b0;
        prog_erase = 1'b0;
        prog_addr = 11'h000;
        prog_wdata = 14'h0000;
    end

    // config access only exists while the programmer owns the part
    task set_mode(input logic m);
        @(posedge core_clk);
        prog_mode <= m;
    endtask : set_mode

    // got stays low when no answer came within the limit
    task xfer(input logic we, input logic cfg, input logic er, input logic [10:0] a,
              input logic [13:0] d, output logic got, output logic [13:0] q, output logic den);
        int i;
        got = 1'b0;
        q = 14'h0000;
        den = 1'b0;
        repeat ($urandom_range(0, 2)) @(posedge core_clk);
        @(posedge core_clk);
        prog_req <= 1'b1;
        prog_we <= we;
        prog_cfg <= cfg;
        prog_erase <= er;
        prog_addr <= a;
        prog_wdata <= d;
        @(posedge core_clk);
        // released qualifiers must not keep looking valid
        prog_req <= 1'b0;
        prog_addr <= ~a;
        prog_wdata <= ~d;
        for (i = 0; i < (er ? 2100 : 4) && !got; i++) begin
            @(posedge core_clk);
            if (prog_ack === 1'b1) begin
                got = 1'b1;
                q = prog_rdata;
                den = prog_denied;
            end
        end
    endtask : xfer
endmodule : pfp_prog_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic        core_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        prog_mode, prog_req, prog_we, prog_cfg, prog_erase, prog_ack, prog_denied;
    logic        nvm_busy, wp, got, den, err;
    logic [10:0] prog_addr, a, r;
    logic [13:0] prog_wdata, prog_rdata, cfg, d1, d2, exp_w, q14;
    logic [1:0]  cp;
    logic [3:0]  pol;
    int          fail_count, check_count, c, k;
    int unsigned seed;

    pfp_flash_protect uut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prog_mode(prog_mode),
        .prog_req(prog_req), .prog_we(prog_we), .prog_cfg(prog_cfg), .prog_erase(prog_erase),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
        .prog_ack(prog_ack), .prog_denied(prog_denied), .nvm_busy(nvm_busy));

    pfp_prog_model pm (.core_clk(core_clk), .prog_mode(prog_mode), .prog_req(prog_req),
        .prog_we(prog_we), .prog_cfg(prog_cfg), .prog_erase(prog_erase),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
        .prog_ack(prog_ack), .prog_denied(prog_denied));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // bits: internal read, internal write, programmer read, programmer write
    function automatic logic [3:0] policy(logic [1:0] p, logic w, logic [10:0] ad);
        logic prot;
        prot = (p == pfp_pkg::CP_HALF && ad >= pfp_pkg::PROT_BASE_HALF) ||
               (p == pfp_pkg::CP_QTR && ad >= pfp_pkg::PROT_BASE_QTR);
        if (p == pfp_pkg::CP_ALL || prot) return 4'h8;
        if (p == pfp_pkg::CP_OFF) return w ? 4'hF : 4'hB;
        return w ? 4'hE : 4'hA;
    endfunction : policy

    task check_word(input string what, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : check_word

    task check_flag(input string what, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, e, s);
        end
    endtask : check_flag

    task wb_xfer(input logic we, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] o);
        int i;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (wb_ack_o === 1'b1) break;
        end
        check_flag("wb_ack", 1'b1, wb_ack_o);
        o = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_dat_i <= ~wb_dat_i;
    endtask : wb_xfer

    task fw_setup(input logic [10:0] ad, input logic [13:0] d);
        wb_xfer(1'b1, pfp_pkg::IDX_ADDR_LO, ad[7:0], q);
        wb_xfer(1'b1, pfp_pkg::IDX_ADDR_HI, {5'h00, ad[10:8]}, q);
        wb_xfer(1'b1, pfp_pkg::IDX_DATA_LO, d[7:0], q);
        wb_xfer(1'b1, pfp_pkg::IDX_DATA_HI, {2'h0, d[13:8]}, q);
        wb_xfer(1'b0, pfp_pkg::IDX_ADDR_LO, 8'h00, q);
        check_word("addr_lo_reg", {24'h000000, ad[7:0]}, q);
    endtask : fw_setup

    // unlock pair immediately precedes the strobe, else the strobe is dropped
    task fw_write(input logic pgm, input logic [10:0] ad, input logic [13:0] d, output logic e);
        fw_setup(ad, d);
        wb_xfer(1'b1, pfp_pkg::IDX_ACCESS_CTL, {pgm, 7'h04}, q);
        wb_xfer(1'b1, pfp_pkg::IDX_UNLOCK, pfp_pkg::UNLOCK_KEY1, q);
        wb_xfer(1'b1, pfp_pkg::IDX_UNLOCK, pfp_pkg::UNLOCK_KEY2, q);
        wb_xfer(1'b1, pfp_pkg::IDX_ACCESS_CTL, {pgm, 7'h06}, q);
        wb_xfer(1'b0, pfp_pkg::IDX_ACCESS_CTL, 8'h00, q);
        e = q[pfp_pkg::ACTL_ERR];
    endtask : fw_write

    task fw_read(input logic pgm, input logic [10:0] ad, output logic [13:0] w);
        fw_setup(ad, 14'h0000);
        wb_xfer(1'b1, pfp_pkg::IDX_ACCESS_CTL, {pgm, 7'h01}, q);
        wb_xfer(1'b0, pfp_pkg::IDX_DATA_LO, 8'h00, q);
        w[7:0] = q[7:0];
        wb_xfer(1'b0, pfp_pkg::IDX_DATA_HI, 8'h00, q);
        w[13:8] = q[5:0];
    endtask : fw_read

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // eight erase walks of about 2050 cycles plus bus traffic
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        $display("mismatch watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        srst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        fail_count = 0;
        check_count = 0;
        seed = $urandom(52);
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        wb_xfer(1'b0, 10'h000, 8'h00, q);
        check_word("unmapped_rd", 32'h00000000, q);
        wb_xfer(1'b0, pfp_pkg::IDX_UNLOCK, 8'h00, q);
        check_word("unlock_rd", 32'h00000000, q);
        for (c = 0; c < 8; c++) begin
            cp = c[2:1];
            wp = c[0];
            pm.set_mode(1'b1);
            pm.xfer(1'b0, 1'b0, 1'b1, 11'h000, 14'h0000, got, q14, den);
            check_flag("erase_ack", 1'b1, got);
            check_flag("busy_after_erase", 1'b0, nvm_busy);
            cfg = 14'h3FFF;
            cfg[pfp_pkg::CFG_WP] = wp;
            cfg[pfp_pkg::CFG_CP_HI -: 2] = cp;
            pm.xfer(1'b1, 1'b1, 1'b0, 11'h000, cfg, got, q14, den);
            pm.xfer(1'b1, 1'b1, 1'b0, 11'h000, 14'h3FFF, got, q14, den);
            pm.set_mode(1'b0);
            pm.xfer(1'b1, 1'b1, 1'b0, 11'h000, 14'h0000, got, q14, den);
            check_flag("cfg_without_mode", 1'b0, got);
            pm.set_mode(1'b1);
            pm.xfer(1'b0, 1'b1, 1'b0, 11'h000, 14'h0000, got, q14, den);
            check_word("cfg_word", 32'(cfg), 32'(q14));
            for (k = 0; k < 3; k++) begin
                r = 11'($urandom);
                case (k)
                    0: a = wp ? 11'h3FF : {1'b0, r[9:0]};
                    1: a = wp ? 11'h400 : {2'h2, r[8:0]};
                    default: a = wp ? 11'h600 : {2'h3, r[8:0]};
                endcase
                d1 = 14'($urandom);
                d2 = 14'($urandom);
                pol = policy(cp, wp, a);
                pm.xfer(1'b1, 1'b0, 1'b0, a, d1, got, q14, den);
                check_flag("ext_wr_denied", !pol[0], den);
                exp_w = pol[0] ? d1 : pfp_pkg::PGM_BLANK;
                pm.set_mode(1'b0);
                fw_write(1'b1, a, d2, err);
                check_flag("int_wr_error", !pol[2], err);
                if (pol[2]) exp_w = d2;
                fw_read(1'b1, a, q14);
                check_word("int_rd_word", 32'(exp_w), 32'(q14));
                pm.set_mode(1'b1);
                pm.xfer(1'b0, 1'b0, 1'b0, a, 14'h0000, got, q14, den);
                check_flag("ext_rd_denied", !pol[1], den);
                if (!pol[1]) exp_w = pfp_pkg::DENIED_WORD;
                check_word("ext_rd_word", 32'(exp_w), 32'(q14));
            end
        end
        // data eeprom: only programmer ownership refuses firmware writes there
        a = 11'($urandom_range(0, 63));
        d1 = 14'($urandom_range(0, 255));
        fw_write(1'b0, a, d1, err);
        check_flag("ee_wr_busy_error", 1'b1, err);
        pm.set_mode(1'b0);
        fw_read(1'b0, a, q14);
        check_word("ee_rd_blank", 32'(pfp_pkg::EE_BLANK), 32'(q14));
        fw_write(1'b0, a, d1, err);
        check_flag("ee_wr_error", 1'b0, err);
        fw_read(1'b0, a, q14);
        check_word("ee_rd_word", 32'(d1), 32'(q14));
        print_verdict();
    end
endmodule : testbench
